// *** dv/gpb_board.sv ***
// Board model: drives, pulls or leaves floating the port pins
module gpb_board (
  input wire logic i_clock,
  input wire logic [7:0] i_pin_out,
  input wire logic [7:0] i_pin_oe,
  input wire logic [7:0] i_pullup_en,
  input wire logic [7:0] i_ext,
  input wire logic [7:0] i_ext_en,
  output logic [7:0] o_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] float_r = 8'h55;
  // A floating pin wanders so that nothing can rely on it
  always @(posedge i_clock)
    float_r <= ~float_r;
  always_comb
    for (int b = 0; b < 8; b++)
      o_pin[b] = i_pin_oe[b] ? i_pin_out[b] : i_ext_en[b] ? i_ext[b]
        : i_pullup_en[b] ? 1'h1 : float_r[b];
endmodule

// *** dv/gpb_checker.sv ***
// Port-level assertions for the change-interrupt I/O port
module gpb_checker (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_warm_rst_n,
  input wire logic [gpb_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [gpb_pkg::DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [gpb_pkg::DATA_W-1:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic [gpb_pkg::PORT_W-1:0] i_pin_in,
  input wire logic [gpb_pkg::PORT_W-1:0] o_pin_oe,
  input wire logic [gpb_pkg::PORT_W-1:0] o_pullup_en,
  input wire logic o_irq,
  input wire logic o_wake
);
  import gpb_pkg::*;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  wire wr_e1 = i_avs_write & !o_avs_waitrequest & i_avs_byteenable[0];
  wire rd_e1 = i_avs_read & !o_avs_waitrequest;
  logic ctl_wr_r;
  // Warm reset restores the global disable, so the flag drops with it
  always_ff @(posedge i_clock or negedge i_rst_n)
    if (!i_rst_n)
      ctl_wr_r <= 1'h0;
    else if (!i_warm_rst_n)
      ctl_wr_r <= 1'h0;
    else if (wr_e1 && i_avs_address == OFS_CTRL)
      ctl_wr_r <= 1'h1;
  ////////////////////////////////////////
  oe_follow_a:
    assert property (wr_e1 && i_avs_address == OFS_DIR && i_warm_rst_n
      |-> ##2 o_pin_oe[5:0] == ~$past(i_avs_writedata[5:0], 2))
    else $error("pin enable does not follow direction");
  pull_off_a:
    assert property ((o_pullup_en[5:0] & o_pin_oe[5:0]
      & $past(o_pin_oe[5:0])) == 6'h00)
    else $error("pull-up on a driven pin");
  pull_global_a:
    assert property (!ctl_wr_r && !$past(ctl_wr_r) |-> o_pullup_en == 8'h00)
    else $error("pull-up on while globally disabled");
  wait_one_a:
    assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
      && i_warm_rst_n |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("wait request not low for one cycle");
  idle_wait_a:
    assert property (!i_avs_read && !i_avs_write |=> o_avs_waitrequest)
    else $error("wait request low without a request");
  data_pins_a:
    assert property (rd_e1 && i_avs_address == OFS_DATA
      |-> o_avs_readdata[7:0] == $past(i_pin_in))
    else $error("port read differs from pin levels");
  ioc_zero_a:
    assert property (rd_e1 && i_avs_address == OFS_IOC
      |-> o_avs_readdata[3:0] == 4'h0)
    else $error("low change enable bits not zero");
  wake_irq_a:
    assert property (o_wake |-> o_irq)
    else $error("wake without interrupt");
endmodule
bind gpb_port gpb_checker gpb_checker_i (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_warm_rst_n(i_warm_rst_n),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_pin_in(i_pin_in),
  .o_pin_oe(o_pin_oe), .o_pullup_en(o_pullup_en), .o_irq(o_irq),
  .o_wake(o_wake));

// *** dv/testbench.sv ***
// Self-checking bench for the change-interrupt I/O port
module testbench;
  import gpb_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, rst_n = 1'h0, warm_n = 1'h1, rd = 1'h0, wr = 1'h0;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] be = 4'hF;
  logic [7:0] pins, pout, poe, pu, ext = 8'h00, ext_en = 8'hFF;
  logic [7:0] q, d, l, w;
  logic irq, wake, wreq, pclk, pdat, pm = 1'h0, pdo = 1'h0;
  int fails = 0, n_checks = 0;
  logic [5:0] ra[4] = '{OFS_DIR, OFS_IOC, OFS_WPU, 6'h3C};
  logic [7:0] rv[4] = '{8'hFF, 8'h00, 8'hFF, 8'h00};
  always #50 clk = ~clk;
  gpb_port gpb_port_i (.i_clock(clk), .i_rst_n(rst_n),
    .i_warm_rst_n(warm_n), .i_clk_en(1'h1), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_pin_in(pins), .o_pin_out(pout),
    .o_pin_oe(poe), .o_pullup_en(pu), .i_prog_mode(pm),
    .i_prog_dat_out(pdo), .i_prog_dat_oe(pdo), .o_prog_clk(pclk),
    .o_prog_dat(pdat), .o_irq(irq), .o_wake(wake));
  gpb_board gpb_board_i (.i_clock(clk), .i_pin_out(pout), .i_pin_oe(poe),
    .i_pullup_en(pu), .i_ext(ext), .i_ext_en(ext_en), .o_pin(pins));
  ////////////////////////////////////////
  function automatic logic [7:0] pin_exp(input logic [7:0] dr, lt, e);
    return (~dr & lt) | (dr & e);
  endfunction
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Holds the request until wait request is seen low at an edge
  task automatic bus(input logic w1, input logic [5:0] a,
    input logic [7:0] dt, output logic [7:0] r);
    int n;
    n = 0;
    addr <= a;
    wdata <= {24'h0, dt};
    rd <= !w1;
    wr <= w1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wreq !== 1'h0 && n < 50);
    if (wreq !== 1'h0)
    begin
      fails++;
      stop_test();
    end
    r = rdata[7:0];
    rd <= 1'h0;
    wr <= 1'h0;
    @(posedge clk);
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    stop_test();
  end
  ////////////////////////////////////////
  initial
  begin
    void'($urandom(5259));
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk);
    foreach (ra[i])
    begin
      bus(1'h0, ra[i], 8'h00, q);
      chk(rv[i], q);
    end
    repeat (8)
    begin
      d = 8'($urandom);
      l = 8'($urandom);
      bus(1'h1, OFS_DIR, d, q);
      bus(1'h1, OFS_DATA, l, q);
      ext <= 8'($urandom);
      @(posedge clk);
      chk(~d, poe);
      bus(1'h0, OFS_DATA, 8'h00, q);
      chk(pin_exp(d, l, ext), q);
    end
    d = 8'($urandom);
    w = 8'($urandom);
    bus(1'h1, OFS_DIR, d, q);
    bus(1'h1, OFS_WPU, w, q);
    be <= 4'h0;
    bus(1'h1, OFS_WPU, 8'h00, q);
    be <= 4'hF;
    bus(1'h0, OFS_WPU, 8'h00, q);
    chk(w, q);
    chk(8'h00, pu);
    bus(1'h1, OFS_CTRL, 8'h02, q);
    ext_en <= 8'h00;
    @(posedge clk);
    chk(w & d, pu);
    bus(1'h0, OFS_DATA, 8'h00, q);
    chk(d & w, q & d & w);
    ext_en <= 8'hFF;
    ext <= 8'h0F;
    bus(1'h1, OFS_DIR, 8'hFF, q);
    bus(1'h1, OFS_IOC, 8'hFF, q);
    bus(1'h1, OFS_MASK, 8'h01, q);
    bus(1'h0, OFS_DATA, 8'h00, q);
    bus(1'h1, OFS_STAT, 8'h03, q);
    ext <= 8'h0B;
    repeat (3) @(posedge clk);
    chk(8'h00, {7'h0, irq});
    ext <= 8'h2B;
    repeat (3) @(posedge clk);
    chk(8'h01, {7'h0, irq});
    chk(8'h01, {7'h0, wake});
    bus(1'h1, OFS_STAT, 8'h01, q);
    bus(1'h0, OFS_STAT, 8'h00, q);
    chk(8'h01, q & 8'h01);
    bus(1'h0, OFS_DATA, 8'h00, q);
    // One port read refreshes the captured value of every pin
    bus(1'h0, OFS_LAST, 8'h00, q);
    chk(8'h2B, q);
    bus(1'h1, OFS_STAT, 8'h01, q);
    repeat (2) @(posedge clk);
    chk(8'h00, {7'h0, irq});
    ext <= 8'h0B;
    warm_n <= 1'h0;
    @(posedge clk);
    warm_n <= 1'h1;
    @(posedge clk);
    bus(1'h0, OFS_LAST, 8'h00, q);
    chk(8'h2B, q);
    bus(1'h1, OFS_IOC, 8'hF0, q);
    bus(1'h1, OFS_STAT, 8'h03, q);
    repeat (2) @(posedge clk);
    bus(1'h0, OFS_STAT, 8'h00, q);
    chk(8'h01, q & 8'h01);
    // Pin 0 falls, then rises; only the rising edge is flagged
    ext <= 8'h0A;
    repeat (2) @(posedge clk);
    bus(1'h1, OFS_STAT, 8'h02, q);
    bus(1'h0, OFS_STAT, 8'h00, q);
    chk(8'h00, q & 8'h02);
    ext <= 8'h0B;
    repeat (2) @(posedge clk);
    bus(1'h0, OFS_STAT, 8'h00, q);
    chk(8'h02, q & 8'h02);
    // Programming mode takes pins 7 and 6
    pm <= 1'h1;
    pdo <= 1'h1;
    ext <= 8'h4B;
    repeat (3) @(posedge clk);
    chk(8'h80, poe & 8'hC0);
    chk(8'h03, {6'h0, pdat, pclk});
    stop_test();
  end
endmodule

// *** rtl/gpb_pin.sv ***
// One port pin: drive, pull-up and change compare
module gpb_pin #(
  parameter bit HAS_IOC = 1'b0
) (
  input wire logic i_dir,
  input wire logic i_wpu,
  input wire logic i_pu_dis,
  input wire logic i_ioc_en,
  input wire logic i_latch,
  input wire logic i_pin,
  input wire logic i_last,
  input wire logic i_prog,
  input wire logic i_prog_oe,
  input wire logic i_prog_out,
  output logic o_oe,
  output logic o_out,
  output logic o_pu,
  output logic o_mismatch
);
  assign o_oe = i_prog ? i_prog_oe : !i_dir;
  assign o_out = i_prog ? i_prog_out : i_latch;
  assign o_pu = i_wpu && !i_pu_dis && !o_oe;
  assign o_mismatch = HAS_IOC && i_ioc_en && (i_pin != i_last);
endmodule

// *** rtl/gpb_pkg.sv ***
// Constants, register map and types for the change-interrupt I/O port
//
// Summary of operation
// - Eight pins, each independently usable as input or output.
// - Direction bit 1 makes the pin a high-impedance input; 0 drives it.
// - A port data read returns the present level of every pin.
// - Set and clear writes are read-modify-write: pins read, modified, written to latch; data writes load the latch directly.
// - Each pin has a weak pull-up enabled by its pull-up enable bit.
// - A pin's pull-up is forced off while that pin is an output.
// - Pull-ups also need the global control; it disables them after power-on.
// - Change interrupt only on pins 7 to 4; enable bits 3 to 0 read zero.
// - Power-on reset clears all change interrupt enables.
// - Enabled pins compared with last-read value; any mismatch sets the flag.
// - Mismatch keeps setting the flag; a port access refreshes the value.
// - A pending change interrupt can wake the core from sleep.
// - Warm reset leaves the last-read value, so a mismatch persists.
// - A pin change during the read sample instant may go unflagged; here the read stores the byte it returned, so such a change is flagged.
// - Pin 0 also serves as an edge-triggered external interrupt input.
// - Pin 7 is serial programming data, pin 6 its clock.
package gpb_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 6;
  localparam int PORT_W = 8;
  localparam int STAT_W = 2;
  localparam int IOC_LSB = 4;
  localparam int IOC_W = 4;

  localparam logic [ADDR_W-1:0] OFS_DATA = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_DIR = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_IOC = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_WPU = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_STAT = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_MASK = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_LAST = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_SET = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_CLR = 6'h24;

  localparam logic [PORT_W-1:0] DIR_RST = 8'hFF;
  localparam logic [PORT_W-1:0] WPU_RST = 8'hFF;
  localparam logic [IOC_W-1:0] IOC_RST = 4'h0;
  localparam logic [PORT_W-1:0] LATCH_RST = 8'h00;
  localparam logic [PORT_W-1:0] LAST_RST = 8'h00;
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam logic [STAT_W-1:0] STAT_RST = 2'h0;
  localparam logic [STAT_W-1:0] MASK_RST = 2'h0;

  // Control bits: global pull-up disable (1 = off), ext edge (1 = rising)
  localparam int CTRL_PU_DIS = 0;
  localparam int CTRL_EDGE = 1;
  // Status and mask bits
  localparam int ST_CHG = 0;
  localparam int ST_EXT = 1;

  localparam int EXT_INT_BIT = 0;
  localparam logic [PORT_W-1:0] PROG_PINS = 8'hC0;
  localparam int PROG_DAT_BIT = 7;
  localparam int PROG_CLK_BIT = 6;

  typedef enum logic [1:0] {
    GPB_BUS_IDLE = 2'b01,
    GPB_BUS_ACK = 2'b10
  } gpb_bus_e;
endpackage

// *** rtl/gpb_port.sv ***
// Eight-pin I/O port with pull-ups, change interrupt and Avalon-MM registers
module gpb_port (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_warm_rst_n,
  input wire logic i_clk_en,
  input wire logic [gpb_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [gpb_pkg::DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [gpb_pkg::DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [gpb_pkg::PORT_W-1:0] i_pin_in,
  output logic [gpb_pkg::PORT_W-1:0] o_pin_out,
  output logic [gpb_pkg::PORT_W-1:0] o_pin_oe,
  output logic [gpb_pkg::PORT_W-1:0] o_pullup_en,
  input wire logic i_prog_mode,
  input wire logic i_prog_dat_out,
  input wire logic i_prog_dat_oe,
  output logic o_prog_clk,
  output logic o_prog_dat,
  output logic o_irq,
  output logic o_wake
);
  import gpb_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Storage

  gpb_bus_e state_r;
  gpb_bus_e state_nxt;
  logic wait_r;
  logic [DATA_W-1:0] rdata_r;
  logic [PORT_W-1:0] latch_r;
  logic [PORT_W-1:0] latch_nxt;
  logic [PORT_W-1:0] dir_r;
  logic [PORT_W-1:0] dir_nxt;
  logic [IOC_W-1:0] ioc_r;
  logic [IOC_W-1:0] ioc_nxt;
  logic [PORT_W-1:0] wpu_r;
  logic [PORT_W-1:0] wpu_nxt;
  logic [1:0] ctrl_r;
  logic [1:0] ctrl_nxt;
  logic [STAT_W-1:0] stat_r;
  logic [STAT_W-1:0] stat_nxt;
  logic [STAT_W-1:0] mask_r;
  logic [STAT_W-1:0] mask_nxt;
  logic [PORT_W-1:0] last_r;
  logic [PORT_W-1:0] last_nxt;
  logic ext_prev_r;
  logic ext_armed_r;
  logic [PORT_W-1:0] pin_out_r;
  logic [PORT_W-1:0] pin_oe_r;
  logic [PORT_W-1:0] pullup_r;
  logic prog_clk_r;
  logic prog_dat_r;
  logic irq_r;
  logic wake_r;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire req = i_avs_read || i_avs_write;
  wire in_ack = (state_r == GPB_BUS_ACK);
  wire start = req && (state_r == GPB_BUS_IDLE);
  wire acc = req && in_ack;
  wire wr = acc && i_avs_write && i_avs_byteenable[0];
  wire rd = acc && i_avs_read;
  wire [PORT_W-1:0] wdat = i_avs_writedata[PORT_W-1:0];

  wire a_data = (i_avs_address == OFS_DATA);
  wire a_dir = (i_avs_address == OFS_DIR);
  wire a_ioc = (i_avs_address == OFS_IOC);
  wire a_wpu = (i_avs_address == OFS_WPU);
  wire a_ctrl = (i_avs_address == OFS_CTRL);
  wire a_stat = (i_avs_address == OFS_STAT);
  wire a_mask = (i_avs_address == OFS_MASK);
  wire a_last = (i_avs_address == OFS_LAST);
  wire a_set = (i_avs_address == OFS_SET);
  wire a_clr = (i_avs_address == OFS_CLR);

  // Illegal codes fall back to idle so an upset cannot hang the bus
  always_comb
  begin
    unique case (state_r)
      GPB_BUS_IDLE:
        state_nxt = start ? GPB_BUS_ACK : GPB_BUS_IDLE;
      GPB_BUS_ACK:
        state_nxt = GPB_BUS_IDLE;
      default:
        state_nxt = GPB_BUS_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path

  wire [PORT_W-1:0] rd_port = i_pin_in;
  wire [PORT_W-1:0] rd_ioc = {ioc_r, {IOC_LSB{1'b0}}};
  wire [PORT_W-1:0] rd_mux =
    a_data ? rd_port :
    a_dir ? dir_r :
    a_ioc ? rd_ioc :
    a_wpu ? wpu_r :
    a_ctrl ? {{(PORT_W-2){1'b0}}, ctrl_r} :
    a_stat ? {{(PORT_W-STAT_W){1'b0}}, stat_r} :
    a_mask ? {{(PORT_W-STAT_W){1'b0}}, mask_r} :
    a_last ? last_r :
    {PORT_W{1'b0}};
  wire [DATA_W-1:0] rd_word = {{(DATA_W-PORT_W){1'b0}}, rd_mux};

  ////////////////////////////////////////////////////////////////////////
  // Register writes

  // Set and clear windows modify the sampled pins, not the latch
  wire port_wr = wr && (a_data || a_set || a_clr);
  assign latch_nxt =
    (wr && a_data) ? wdat :
    (wr && a_set) ? (i_pin_in | wdat) :
    (wr && a_clr) ? (i_pin_in & ~wdat) :
    latch_r;
  assign dir_nxt = (wr && a_dir) ? wdat : dir_r;
  assign ioc_nxt = (wr && a_ioc) ? wdat[PORT_W-1:IOC_LSB] : ioc_r;
  assign wpu_nxt = (wr && a_wpu) ? wdat : wpu_r;
  assign ctrl_nxt = (wr && a_ctrl) ? wdat[1:0] : ctrl_r;
  assign mask_nxt = (wr && a_mask) ? wdat[STAT_W-1:0] : mask_r;

  // Any port access refreshes the compare value
  // Read captures exactly the byte returned, so a change in between shows
  // Change at the read sample instant
  assign last_nxt =
    (rd && a_data) ? rdata_r[PORT_W-1:0] :
    port_wr ? i_pin_in :
    last_r;

  ////////////////////////////////////////////////////////////////////////
  // Pins

  logic [PORT_W-1:0] oe_w;
  logic [PORT_W-1:0] out_w;
  logic [PORT_W-1:0] pu_w;
  logic [PORT_W-1:0] mis_w;
  // Pins 7 and 6 handed to the programming interface
  // Programming mode never touches the latch, so user data survive it
  wire [PORT_W-1:0] prog_sel = i_prog_mode ? PROG_PINS : {PORT_W{1'b0}};
  wire [PORT_W-1:0] prog_oe = {i_prog_dat_oe, {(PORT_W-1){1'b0}}};
  wire [PORT_W-1:0] prog_out = {i_prog_dat_out, {(PORT_W-1){1'b0}}};
  wire [PORT_W-1:0] ioc_full = {ioc_r, {IOC_LSB{1'b0}}};

  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++)
    begin : g_pin
      gpb_pin #(
        .HAS_IOC(gi >= IOC_LSB)
      ) u_pin (
        .i_dir(dir_r[gi]),
        .i_wpu(wpu_r[gi]),
        .i_pu_dis(ctrl_r[CTRL_PU_DIS]),
        .i_ioc_en(ioc_full[gi]),
        .i_latch(latch_r[gi]),
        .i_pin(i_pin_in[gi]),
        .i_last(last_r[gi]),
        .i_prog(prog_sel[gi]),
        .i_prog_oe(prog_oe[gi]),
        .i_prog_out(prog_out[gi]),
        .o_oe(oe_w[gi]),
        .o_out(out_w[gi]),
        .o_pu(pu_w[gi]),
        .o_mismatch(mis_w[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Events and interrupt

  wire chg_set = |mis_w;
  // Pin 0 edge, polarity from control
  wire ext_pin = i_pin_in[EXT_INT_BIT];
  wire ext_rise = ext_pin && !ext_prev_r;
  wire ext_fall = !ext_pin && ext_prev_r;
  // No edge is reported until the detector has seen the pin once
  wire ext_sel = ctrl_r[CTRL_EDGE] ? ext_rise : ext_fall;
  wire ext_set = ext_armed_r && ext_sel;
  wire [STAT_W-1:0] ev_set = {ext_set, chg_set};
  wire [STAT_W-1:0] w1c = (wr && a_stat) ? wdat[STAT_W-1:0] : '0;
  // Set beats a clear in the same cycle
  assign stat_nxt = (stat_r & ~w1c) | ev_set;
  // Flag and enable both needed
  // Registered below so the line carries no decode glitches
  wire irq_nxt = |(stat_r & mask_r);
  wire wake_nxt = stat_r[ST_CHG] && mask_r[ST_CHG];

  ////////////////////////////////////////////////////////////////////////
  // Bus slave flops

  // Read data are captured at request time and held to the next access
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_r <= GPB_BUS_IDLE;
      wait_r <= 1'b1;
      rdata_r <= '0;
    end
    else if (i_clk_en)
    begin
      if (!i_warm_rst_n)
      begin
        state_r <= GPB_BUS_IDLE;
        wait_r <= 1'b1;
      end
      else
      begin
        state_r <= state_nxt;
        wait_r <= !start;
        if (start)
        begin
          rdata_r <= rd_word;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration, restored to its reset values by every reset

  // Global pull-up disable set on power-on
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      dir_r <= DIR_RST;
      ioc_r <= IOC_RST;
      wpu_r <= WPU_RST;
      ctrl_r <= CTRL_RST;
      mask_r <= MASK_RST;
    end
    else if (i_clk_en)
    begin
      if (!i_warm_rst_n)
      begin
        dir_r <= DIR_RST;
        ioc_r <= IOC_RST;
        wpu_r <= WPU_RST;
        ctrl_r <= CTRL_RST;
        mask_r <= MASK_RST;
      end
      else
      begin
        dir_r <= dir_nxt;
        ioc_r <= ioc_nxt;
        wpu_r <= wpu_nxt;
        ctrl_r <= ctrl_nxt;
        mask_r <= mask_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Port state, kept through a warm reset

  // Last-read value and flag survive warm reset
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      latch_r <= LATCH_RST;
      last_r <= LAST_RST;
      stat_r <= STAT_RST;
      ext_prev_r <= 1'b0;
    end
    else if (i_clk_en)
    begin
      latch_r <= i_warm_rst_n ? latch_nxt : latch_r;
      last_r <= i_warm_rst_n ? last_nxt : last_r;
      stat_r <= i_warm_rst_n ? stat_nxt : (stat_r | ev_set);
      ext_prev_r <= ext_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Edge detector arming

  // The pin's idle level is unknown at reset, so the first edge only primes
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ext_armed_r <= 1'b0;
    end
    else if (i_clk_en)
    begin
      ext_armed_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pin_out_r <= LATCH_RST;
      pin_oe_r <= '0;
      pullup_r <= '0;
      prog_clk_r <= 1'b0;
      prog_dat_r <= 1'b0;
      irq_r <= 1'b0;
      wake_r <= 1'b0;
    end
    else if (i_clk_en)
    begin
      pin_out_r <= out_w;
      pin_oe_r <= oe_w;
      pullup_r <= pu_w;
      // Programming clock and data from pins 6 and 7
      prog_clk_r <= i_pin_in[PROG_CLK_BIT];
      prog_dat_r <= i_pin_in[PROG_DAT_BIT];
      irq_r <= irq_nxt;
      wake_r <= wake_nxt;
    end
  end

  assign o_avs_readdata = rdata_r;
  assign o_avs_waitrequest = wait_r;
  assign o_pin_out = pin_out_r;
  assign o_pin_oe = pin_oe_r;
  assign o_pullup_en = pullup_r;
  assign o_prog_clk = prog_clk_r;
  assign o_prog_dat = prog_dat_r;
  assign o_irq = irq_r;
  assign o_wake = wake_r;
endmodule
